/* File: hdl/ufx_level_status.v */
// FIFO fill and empty level counters, transmit threshold, three compare
// characters and the clear-on-read flow-character event status, on APB.
// Assumes the FIFO, receiver and transmitter run on pclk and give one-cycle
// push, pop, character and sent strobes; no synchronisers are needed.
//
// Behaviour
// - Receive fill count reads 1..255 as plain binary.
// - Fill count zero with receive-ready set means 256 entries full.
// - Writable 8-bit transmit threshold; reaching it requests transmit service.
// - Writing the threshold overrides the mode register trigger level.
// - Transmit empty count reads 1..255 free slots as plain binary.
// - Empty count zero with transmit-ready set means 256 slots free.
// - Resume compare character, writable, resets to 0x11.
// - Pause compare character, writable, resets to 0x13.
// - Wake-up address compare character, writable, resets to 0x00.
// - Compare registers are plain patterns with no fixed hardware action.
// - Matches drive flow, wake-up or interrupt only when enabled.
// - Reading event status clears its upper four bits after returning them.
// - Bits 7:6: 01 pause seen, 10 resume seen, 11 both.
// - Received flags accumulate until the host reads the register.
// - Received flags update regardless of flow and interrupt enables.
// - Every received character is compared with resume and pause registers.
// - Bits 5:4: 01 resume sent, 10 pause sent, 11 both.
// - Sent field reads 00 while automatic flow is off; clears on exit.
`timescale 1ns/1ps
`include "ufx_regs.vh"

module ufx_level_status #(
  parameter DEPTH = 256,
  parameter CW = 9
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // FIFO activity strobes
  input wire rx_push,
  input wire rx_pop,
  input wire tx_push,
  input wire tx_pop,
  // Receiver character and transmitted flow characters
  input wire rx_char_valid,
  input wire [7:0] rx_char,
  input wire tx_resume_sent,
  input wire tx_pause_sent,
  // Mode register trigger level, used until the threshold is written
  input wire [7:0] mode_tx_trigger,
  // Status and match outputs
  output wire receive_ready_flag,
  output wire transmit_ready_flag,
  output wire tx_service_req,
  output wire flow_pause_hit,
  output wire flow_resume_hit,
  output wire wakeup_hit,
  output wire match_irq
);

  // Limitation: the counters trust the FIFO side. A push into a full FIFO
  // or a pop from an empty one wraps the count; the FIFO control that
  // drives the strobes is expected to block both.

  // Event flags sit at their status-byte position minus the field base
  localparam EV_BASE = `UFX_EVT_TX_RESUME;
  localparam EV_TX_RESUME = `UFX_EVT_TX_RESUME - EV_BASE;
  localparam EV_TX_PAUSE = `UFX_EVT_TX_PAUSE - EV_BASE;
  localparam EV_RX_PAUSE = `UFX_EVT_RX_PAUSE - EV_BASE;
  localparam EV_RX_RESUME = `UFX_EVT_RX_RESUME - EV_BASE;
  // Compare bank: one slot per character register
  localparam NCMP = 3;
  localparam SLOT_RESUME = 0;
  localparam SLOT_PAUSE = 1;
  localparam SLOT_WAKE = 2;
  // Counter constants at counter width; level zero at the 8-bit register width
  localparam [CW-1:0] FREE_ALL = DEPTH[CW-1:0];
  localparam [CW-1:0] CNT_ZERO = {CW{1'b0}};
  localparam [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};
  localparam [7:0] LEVEL_ZERO = 8'h00;

  // Level counters: occupancy of each FIFO, 0..DEPTH, one bit wider than
  // the 8-bit register codes so that full and empty are told apart
  reg [CW-1:0] rx_cnt_ff;
  reg [CW-1:0] tx_used_ff;
  reg [CW-1:0] nxt_rx_cnt;
  reg [CW-1:0] nxt_tx_used;
  // Compare characters and transmit threshold
  reg [7:0] resume_ff;
  reg [7:0] pause_ff;
  reg [7:0] wakeup_ff;
  reg [7:0] thresh_ff;
  reg thresh_written_ff;
  // Match control: flow enable, wake enable, match interrupt enable
  reg [3:1] ctrl_ff;
  // Sticky flow-character events and the next value
  reg [3:0] evt_ff;
  reg [3:0] nxt_evt;
  // Registered match pulses: [0] pause, [1] resume, [2] wake-up
  reg [2:0] hit_ff;
  reg [2:0] nxt_hit;
  // Read path
  reg [7:0] status_byte;
  reg [31:0] nxt_rdata;

  // APB phase decode; the slave never stretches a transfer
  wire [9:0] idx = paddr[11:2];
  wire setup = psel & ~penable;
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;

  // Register selects; paddr[1:0] is ignored, unmapped indices select nothing
  wire sel_rx_fill = (idx == {2'b00, `UFX_IDX_RX_FILL});
  wire sel_tx_empty = (idx == {2'b00, `UFX_IDX_TX_EMPTY});
  wire sel_resume = (idx == {2'b00, `UFX_IDX_RESUME});
  wire sel_pause = (idx == {2'b00, `UFX_IDX_PAUSE});
  wire sel_wakeup = (idx == {2'b00, `UFX_IDX_WAKEUP});
  wire sel_evt = (idx == {2'b00, `UFX_IDX_EVT_STAT});
  wire sel_thresh = (idx == {2'b00, `UFX_IDX_TX_THRESH});
  wire sel_ctrl = (idx == {2'b00, `UFX_IDX_MATCH_CTRL});
  wire sel_mstat = (idx == {2'b00, `UFX_IDX_MATCH_STAT});

  // Free slots; an empty FIFO gives DEPTH, whose low byte is the zero code
  wire [CW-1:0] tx_free = FREE_ALL - tx_used_ff;
  wire [7:0] tx_free8 = tx_free[7:0];
  wire [7:0] rx_cnt8 = rx_cnt_ff[7:0];
  wire flow_en = ctrl_ff[`UFX_CTL_FLOW_EN];
  wire wake_en = ctrl_ff[`UFX_CTL_WAKE_EN];
  wire irq_en = ctrl_ff[`UFX_CTL_MATCH_IRQ_EN];

  // Compare bank, packed resume, pause, wake-up from bit 0 upward
  wire [8*NCMP-1:0] cmp_chars = {wakeup_ff, pause_ff, resume_ff};
  wire [NCMP-1:0] cmp_eq;
  wire m_resume = cmp_eq[SLOT_RESUME];
  wire m_pause = cmp_eq[SLOT_PAUSE];
  wire m_wake = cmp_eq[SLOT_WAKE];

  // One comparator per character register. Every received character is
  // checked against all of them whatever the enables say, so the status
  // field doubles as a plain pattern detector.
  genvar gi;
  generate
    for (gi = 0; gi < NCMP; gi = gi + 1) begin : g_cmp
      assign cmp_eq[gi] = rx_char_valid & (rx_char == cmp_chars[gi*8 +: 8]);
    end
  endgenerate

  // Trigger level in force: the written threshold once software has set
  // one, the mode register level before that
  wire [7:0] eff_level = thresh_written_ff ? thresh_ff : mode_tx_trigger;

  // Zero-wait slave, errors never reported
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Ready flags give the ninth bit that the 8-bit count codes drop
  assign receive_ready_flag = (rx_cnt_ff != CNT_ZERO);
  assign transmit_ready_flag = (tx_free != CNT_ZERO);

  // Service request when free slots reach the effective level. A level of
  // zero stands for 256 free positions, so it only fires on an empty FIFO;
  // the top bit of tx_free is set only in that case.
  assign tx_service_req = transmit_ready_flag &
    ((tx_free[CW-1] == 1'b1) ||
     ((eff_level != LEVEL_ZERO) && (tx_free8 >= eff_level)));

  // Match actions are gated by enables, never by register name alone
  assign flow_pause_hit = hit_ff[0];
  assign flow_resume_hit = hit_ff[1];
  assign wakeup_hit = hit_ff[2];
  // Interrupt only from received flow characters and only when enabled
  assign match_irq = irq_en & (evt_ff[EV_RX_RESUME] | evt_ff[EV_RX_PAUSE]);

  // Receive level: push and pop in one cycle cancel. Strobes must last one
  // cycle; a held strobe counts once per edge.
  always @* begin
    nxt_rx_cnt = rx_cnt_ff;
    if (rx_push & ~rx_pop) begin
      nxt_rx_cnt = rx_cnt_ff + CNT_ONE;
    end else if (rx_pop & ~rx_push) begin
      nxt_rx_cnt = rx_cnt_ff - CNT_ONE;
    end
  end

  // Transmit level, same rules; free slots are derived from it
  always @* begin
    nxt_tx_used = tx_used_ff;
    if (tx_push & ~tx_pop) begin
      nxt_tx_used = tx_used_ff + CNT_ONE;
    end else if (tx_pop & ~tx_push) begin
      nxt_tx_used = tx_used_ff - CNT_ONE;
    end
  end

  // Event status. A set in the read cycle survives the clear; a set in the
  // setup cycle misses the returned value and is then lost to the clear.
  always @* begin
    nxt_evt = evt_ff;
    if (rd && sel_evt) begin
      nxt_evt = 4'h0;
    end
    if (m_resume) begin
      nxt_evt[EV_RX_RESUME] = 1'b1;
    end
    if (m_pause) begin
      nxt_evt[EV_RX_PAUSE] = 1'b1;
    end
    if (flow_en & tx_pause_sent) begin
      nxt_evt[EV_TX_PAUSE] = 1'b1;
    end
    if (flow_en & tx_resume_sent) begin
      nxt_evt[EV_TX_RESUME] = 1'b1;
    end
    // Sent flags read zero whenever automatic flow control is off
    if (~flow_en) begin
      nxt_evt[EV_TX_PAUSE] = 1'b0;
      nxt_evt[EV_TX_RESUME] = 1'b0;
    end
  end

  // Match pulses, one cycle after the character, only with the matching enable
  always @* begin
    nxt_hit = 3'b000;
    nxt_hit[0] = m_pause & flow_en;
    nxt_hit[1] = m_resume & flow_en;
    nxt_hit[2] = m_wake & wake_en;
  end

  // Status byte: received and sent flags at their fields. The low nibble
  // belongs to transmitter state outside this slice and reads zero here.
  always @* begin
    status_byte = 8'h00;
    status_byte[`UFX_EVT_RX_RESUME] = evt_ff[EV_RX_RESUME];
    status_byte[`UFX_EVT_RX_PAUSE] = evt_ff[EV_RX_PAUSE];
    status_byte[`UFX_EVT_TX_PAUSE] = evt_ff[EV_TX_PAUSE];
    status_byte[`UFX_EVT_TX_RESUME] = evt_ff[EV_TX_RESUME];
  end

  // Receive level register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt_ff <= CNT_ZERO;
    end else begin
      rx_cnt_ff <= nxt_rx_cnt;
    end
  end

  // Transmit level register; reset means an empty FIFO, all slots free
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_used_ff <= CNT_ZERO;
    end else begin
      tx_used_ff <= nxt_tx_used;
    end
  end

  // Sticky event flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_ff <= 4'h0;
    end else begin
      evt_ff <= nxt_evt;
    end
  end

  // Match pulses last exactly one cycle; registered so that downstream
  // logic sees a clean strobe rather than a comparator glitch
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_ff <= 3'b000;
    end else begin
      hit_ff <= nxt_hit;
    end
  end

  // Resume compare character
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_ff <= `UFX_RST_RESUME;
    end else if (wr && sel_resume) begin
      resume_ff <= pwdata[7:0];
    end
  end

  // Pause compare character
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_ff <= `UFX_RST_PAUSE;
    end else if (wr && sel_pause) begin
      pause_ff <= pwdata[7:0];
    end
  end

  // Wake-up address compare character
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wakeup_ff <= `UFX_RST_WAKEUP;
    end else if (wr && sel_wakeup) begin
      wakeup_ff <= pwdata[7:0];
    end
  end

  // Transmit threshold value; zero means 256 free positions
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thresh_ff <= `UFX_RST_THRESH;
    end else if (wr && sel_thresh) begin
      thresh_ff <= pwdata[7:0];
    end
  end

  // Threshold override: set by a threshold write, handed back to the mode
  // level when software writes the control word with the override bit low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thresh_written_ff <= 1'b0;
    end else if (wr && sel_thresh) begin
      thresh_written_ff <= 1'b1;
    end else if (wr && sel_ctrl && !pwdata[`UFX_CTL_THRESH_OVR]) begin
      thresh_written_ff <= 1'b0;
    end
  end

  // Match control word; bit 0 reads back the override state instead.
  // One local word keeps this slice free of the mode registers.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= 3'b000;
    end else if (wr && sel_ctrl) begin
      ctrl_ff <= pwdata[3:1];
    end
  end

  // Read mux, in the order of the register map. Unmapped indices read zero;
  // count registers have no write path at all.
  always @* begin
    nxt_rdata = 32'h00000000;
    if (sel_rx_fill) begin
      nxt_rdata[7:0] = rx_cnt8;
    end else if (sel_tx_empty) begin
      nxt_rdata[7:0] = tx_free8;
    end else if (sel_resume) begin
      nxt_rdata[7:0] = resume_ff;
    end else if (sel_pause) begin
      nxt_rdata[7:0] = pause_ff;
    end else if (sel_wakeup) begin
      nxt_rdata[7:0] = wakeup_ff;
    end else if (sel_evt) begin
      nxt_rdata[7:0] = status_byte;
    end else if (sel_thresh) begin
      nxt_rdata[7:0] = thresh_ff;
    end else if (sel_ctrl) begin
      nxt_rdata[3:0] = {ctrl_ff, thresh_written_ff};
    end else if (sel_mstat) begin
      nxt_rdata[2:0] = {transmit_ready_flag, receive_ready_flag, tx_service_req};
    end
  end

  // Read data is captured on the setup cycle, so it stands through the access
  // phase; the status clear lands at the access edge, after the capture.
  // Writes leave prdata alone.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup & ~pwrite) begin
      prdata <= nxt_rdata;
    end
  end

endmodule

/* File: shared/ufx_regs.vh */
// Register map, reset values and field positions of the UART FIFO level and
// flow-character status slice.
// Included by the design file; holds definitions only.
`ifndef UFX_REGS_VH
`define UFX_REGS_VH

// Printed offsets are register indices; byte address is four times the index
`define UFX_IDX_RX_FILL 8'h10
`define UFX_IDX_TX_EMPTY 8'h11
`define UFX_IDX_RESUME 8'h41
`define UFX_IDX_PAUSE 8'h42
`define UFX_IDX_WAKEUP 8'h43
`define UFX_IDX_EVT_STAT 8'h44
`define UFX_IDX_TX_THRESH 8'h47
`define UFX_IDX_MATCH_CTRL 8'h48
`define UFX_IDX_MATCH_STAT 8'h49

// Reset values
`define UFX_RST_RESUME 8'h11
`define UFX_RST_PAUSE 8'h13
`define UFX_RST_WAKEUP 8'h00
`define UFX_RST_THRESH 8'h00

// Event status field positions
`define UFX_EVT_RX_PAUSE 6
`define UFX_EVT_RX_RESUME 7
`define UFX_EVT_TX_RESUME 4
`define UFX_EVT_TX_PAUSE 5

// Match control bits
`define UFX_CTL_THRESH_OVR 0
`define UFX_CTL_FLOW_EN 1
`define UFX_CTL_WAKE_EN 2
`define UFX_CTL_MATCH_IRQ_EN 3

`endif

/* File: verif/ufx_level_status_properties.sv */
// Port assertions for the FIFO level and flow-character status slice.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module ufx_level_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // FIFO and character strobes
  input wire logic rx_push,
  input wire logic rx_pop,
  input wire logic tx_pop,
  input wire logic rx_char_valid,
  // Flags and match pulses
  input wire logic receive_ready_flag,
  input wire logic transmit_ready_flag,
  input wire logic tx_service_req,
  input wire logic flow_pause_hit,
  input wire logic flow_resume_hit,
  input wire logic wakeup_hit
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Counts move only on strobes sampled at the edge
  rx_push_a: assert property (rx_push && !rx_pop |=> receive_ready_flag)
    else $error("rx ready low after push");
  rx_idle_a: assert property (!rx_push && !rx_pop |=> $stable(receive_ready_flag))
    else $error("rx ready moved without strobe");
  tx_pop_a: assert property (tx_pop |=> transmit_ready_flag)
    else $error("tx ready low after pop");
  // A full transmit FIFO can never reach any threshold
  svc_full_a: assert property (!transmit_ready_flag |-> !tx_service_req)
    else $error("service request with no free slot");
  // Match pulses always trace back to a received character
  pause_cause_a: assert property (flow_pause_hit |-> $past(rx_char_valid))
    else $error("pause hit without character");
  resume_cause_a: assert property (flow_resume_hit |-> $past(rx_char_valid))
    else $error("resume hit without character");
  wake_cause_a: assert property (wakeup_hit |-> $past(rx_char_valid))
    else $error("wake hit without character");
  hit_quiet_a: assert property (!rx_char_valid |=> !(flow_pause_hit || wakeup_hit))
    else $error("hit pulse while line idle");
endmodule
bind ufx_level_status ufx_level_chk chk_u (.*);

/* File: verif/ufx_fifo_side.sv */
// Far-side model: FIFO writer and reader behind the level counters.
// Counts run one edge ahead of the slice; strobes last one cycle.
`timescale 1ns/1ps
module ufx_fifo_side (
  // Clock, reset, mode (0 idle, 1 random, 2 fill, 3 drain)
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] mode,
  input wire logic [3:0] rnd,
  // Strobes and occupancy
  output logic rx_push,
  output logic rx_pop,
  output logic tx_push,
  output logic tx_pop,
  output int rx_used,
  output int tx_used
);
  logic a, b, c, d;
  // Gated by occupancy so nothing is pushed full or popped empty
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rx_push, rx_pop, tx_push, tx_pop} <= 4'h0;
      rx_used <= 0;
      tx_used <= 0;
    end else begin
      a = (mode == 2'h2 || mode == 2'h1 && rnd[0]) && rx_used < 256;
      b = (mode == 2'h3 || mode == 2'h1 && rnd[1]) && rx_used > 0;
      c = (mode == 2'h2 || mode == 2'h1 && rnd[2]) && tx_used < 256;
      d = (mode == 2'h3 || mode == 2'h1 && rnd[3]) && tx_used > 0;
      {rx_push, rx_pop, tx_push, tx_pop} <= {a, b, c, d};
      rx_used <= rx_used + a - b;
      tx_used <= tx_used + c - d;
    end
  end
endmodule

/* File: verif/uart_fifo_level_xchar_status_test.sv */
// Self-checking bench for the level and flow-status slice over APB.
// Assumes the far-side model makes every FIFO strobe.
`timescale 1ns/1ps
module uart_fifo_level_xchar_status_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic rx_push, rx_pop, tx_push, tx_pop, rx_char_valid = 0, tx_resume_sent = 0;
  logic tx_pause_sent = 0, receive_ready_flag, transmit_ready_flag, tx_service_req;
  logic flow_pause_hit, flow_resume_hit, wakeup_hit, match_irq;
  logic [7:0] rx_char = 0, mode_tx_trigger = 0, v [4];
  logic [2:0] h;
  logic [1:0] mode = 0;
  logic [3:0] rnd = 0;
  int seed = 49, bad_count = 0, total_checks = 0, rx_used, tx_used;
  logic [11:0] adr [7] = '{12'h040, 12'h044, 12'h104, 12'h108, 12'h10C, 12'h110, 12'hFF0};
  logic [7:0] rst [7] = '{8'h00, 8'h00, 8'h11, 8'h13, 8'h00, 8'h00, 8'h00};
  logic [11:0] wa [4] = '{12'h104, 12'h108, 12'h10C, 12'h11C};
  always #4 pclk = ~pclk;
  ufx_level_status dut_u (.*);
  ufx_fifo_side far_u (.*);
  // Fresh random strobes and trigger level each cycle
  always @(posedge pclk) begin
    rnd <= $random(seed);
    mode_tx_trigger <= $random(seed);
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request stands until pready is seen high at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'h0, a, 32'h0);
    chk(r, {24'h0, e});
  endtask
  // Hit pulses stand for the cycle after the character; look mid-cycle
  task pulse(input logic [2:0] k, input logic [7:0] c);
    @(posedge pclk);
    {tx_pause_sent, tx_resume_sent, rx_char_valid} <= k;
    rx_char <= c;
    @(posedge pclk);
    {tx_pause_sent, tx_resume_sent, rx_char_valid} <= 3'h0;
    @(negedge pclk);
    h = {wakeup_hit, flow_resume_hit, flow_pause_hit};
  endtask
  task run(input logic [1:0] m);
    mode <= m;
    repeat (300) @(posedge pclk);
    mode <= 2'h0;
    repeat (3) @(posedge pclk);
  endtask
  task final_report;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard, far beyond the thousand or so cycles needed
  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 7; i++) rd(adr[i], rst[i]);
    chk(transmit_ready_flag, 32'h1);
    for (int i = 0; i < 4; i++) begin
      v[i] = {6'($random(seed)), 2'(i)};
      apb(1'h1, wa[i], {24'h0, v[i]});
      rd(wa[i], v[i]);
    end
    apb(1'h1, 12'h040, 32'hFF);
    rd(12'h040, 8'h00);
    run(2'h1);
    rd(12'h040, rx_used[7:0]);
    rd(12'h044, 8'(256 - tx_used));
    run(2'h2);
    rd(12'h040, 8'h00);
    chk(receive_ready_flag, 32'h1);
    chk(tx_service_req, 32'h0);
    run(2'h3);
    rd(12'h044, 8'h00);
    chk({receive_ready_flag, transmit_ready_flag}, 32'h1);
    apb(1'h1, 12'h120, 32'h2);
    pulse(3'h1, v[1]);
    chk(h, 32'h1);
    pulse(3'h3, v[0]);
    chk(h, 32'h2);
    rd(12'h110, 8'hD0);
    rd(12'h110, 8'h00);
    pulse(3'h4, 8'h00);
    rd(12'h110, 8'h20);
    apb(1'h1, 12'h120, 32'h4);
    pulse(3'h5, v[1]);
    chk(h, 32'h0);
    chk(match_irq, 32'h0);
    apb(1'h1, 12'h120, 32'hC);
    @(negedge pclk);
    chk(match_irq, 32'h1);
    rd(12'h110, 8'h40);
    pulse(3'h1, v[2]);
    chk(h, 32'h4);
    chk(match_irq, 32'h0);
    final_report;
  end
endmodule
